// file: sac_capture.sv
// What this block does
// - Address registered only with a strobe low and all three chip selects active.
// - Two low address bits load the two-bit burst counter on every capture.
// - Active-low lane selects are sampled on the rising clock edge.
// - A lane writes when its select and byte write enable are both low, or when global write is low.
// - Global write low writes every lane regardless of selects and byte enable.
// - Each select governs exactly one lane: eight data bits plus its parity bit.
// - Each lane holds eight data bits and one parity bit, thirty-six in total.
// - With both strobes low, only the processor-side strobe is acted upon.
`timescale 1ns/1ns
`default_nettype none

module sac_capture (
   input wire logic clk,
   input wire logic rst,
   input wire logic addr_bit_zero,
   input wire logic addr_bit_one,
   input wire logic [sac_pkg::UPPER_W-1:0] addr_upper,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic chip_sel_first_n,
   input wire logic chip_sel_second,
   input wire logic chip_sel_third_n,
   input wire logic all_lanes_write_n,
   input wire logic byte_write_enable_n,
   input wire logic lane0_write_sel_n,
   input wire logic lane1_write_sel_n,
   input wire logic lane2_write_sel_n,
   input wire logic lane3_write_sel_n,
   input wire logic [sac_pkg::LANE_DATA_W-1:0] lane0_data,
   input wire logic [sac_pkg::LANE_DATA_W-1:0] lane1_data,
   input wire logic [sac_pkg::LANE_DATA_W-1:0] lane2_data,
   input wire logic [sac_pkg::LANE_DATA_W-1:0] lane3_data,
   input wire logic lane0_parity,
   input wire logic lane1_parity,
   input wire logic lane2_parity,
   input wire logic lane3_parity,
   output logic [sac_pkg::UPPER_W-1:0] addr_held,
   output logic [sac_pkg::BURST_W-1:0] burst_count,
   output logic addr_captured,
   output logic strobe_was_proc,
   output logic [sac_pkg::LANES-1:0] lane_write_en,
   output logic [sac_pkg::WORD_W-1:0] write_word,
   output sac_pkg::sac_cycle_e cycle_kind
);

   // ----------------------------------------
   // input qualification
   // ----------------------------------------
   logic chips_selected;
   logic strobe_seen;
   logic capture;
   logic [sac_pkg::LANES-1:0] sel_n_vec;
   logic [sac_pkg::LANES-1:0] next_lane_en;
   logic [sac_pkg::LANE_DATA_W-1:0] data_vec [sac_pkg::LANES];
   logic [sac_pkg::LANES-1:0] parity_vec;

   // all three chip selects in their active state
   assign chips_selected = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
   assign strobe_seen = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
   assign capture = strobe_seen && chips_selected;

   // gather the per-lane pins for the lane loop
   assign sel_n_vec = {lane3_write_sel_n, lane2_write_sel_n, lane1_write_sel_n,
                       lane0_write_sel_n};
   assign parity_vec = {lane3_parity, lane2_parity, lane1_parity, lane0_parity};
   assign data_vec[0] = lane0_data;
   assign data_vec[1] = lane1_data;
   assign data_vec[2] = lane2_data;
   assign data_vec[3] = lane3_data;

   // ----------------------------------------
   // address and burst counter capture
   // ----------------------------------------
   // upper address held between captures
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_held <= sac_pkg::UPPER_RST;
      end else if (capture) begin
         addr_held <= addr_upper;
      end
   end

   // low two bits seed the burst counter
   always_ff @(posedge clk) begin
      if (rst) begin
         burst_count <= sac_pkg::BURST_RST;
      end else if (capture) begin
         burst_count <= {addr_bit_one, addr_bit_zero};
      end
   end

   // capture flag, one cycle per accepted strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_captured <= 1'h0;
      end else begin
         addr_captured <= capture;
      end
   end

   // which strobe started the access; processor side has priority
   always_ff @(posedge clk) begin
      if (rst) begin
         strobe_was_proc <= 1'h0;
      end else if (capture) begin
         strobe_was_proc <= !proc_addr_strobe_n;
      end
   end

   // ----------------------------------------
   // byte lanes
   // ----------------------------------------
   // one lane controller per select, lane i to bits of lane i only
   for (genvar i = 0; i < sac_pkg::LANES; i++) begin : g_lane
      sac_lane i_sac_lane (
         .clk(clk),
         .rst(rst),
         .write_sel_n(sel_n_vec[i]),
         .byte_write_enable_n(byte_write_enable_n),
         .all_lanes_write_n(all_lanes_write_n),
         .lane_data(data_vec[i]),
         .lane_parity(parity_vec[i]),
         .next_write_en(next_lane_en[i]),
         .write_en(lane_write_en[i]),
         .lane_word(write_word[i*sac_pkg::LANE_W +: sac_pkg::LANE_W])
      );
   end

   // ----------------------------------------
   // cycle kind
   // ----------------------------------------
   // no enabled lane leaves the array alone and reads
   always_ff @(posedge clk) begin
      if (rst) begin
         cycle_kind <= sac_pkg::SAC_CYC_IDLE;
      end else begin
         case (|next_lane_en)
            1'h1: cycle_kind <= sac_pkg::SAC_CYC_WRITE;
            1'h0: cycle_kind <= sac_pkg::SAC_CYC_READ;
            default: cycle_kind <= sac_pkg::SAC_CYC_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_capture_taken;
      @(posedge clk) disable iff (rst)
      capture |=> addr_captured && addr_held == $past(addr_upper);
   endproperty
   a_capture_taken: assert property (p_capture_taken)
      else $error("address not captured on qualified strobe");

   property p_no_capture;
      @(posedge clk) disable iff (rst)
      !(strobe_seen && chips_selected) |=> !addr_captured && $stable(addr_held);
   endproperty
   a_no_capture: assert property (p_no_capture)
      else $error("address changed without qualified strobe");

   property p_counter_load;
      @(posedge clk) disable iff (rst)
      capture |=> burst_count == $past({addr_bit_one, addr_bit_zero}) ##1
         (addr_captured || $stable(burst_count));
   endproperty
   a_counter_load: assert property (p_counter_load)
      else $error("burst counter not loaded from low address bits");

   property p_select_sampled;
      @(posedge clk) disable iff (rst)
      (all_lanes_write_n && !byte_write_enable_n) |=> lane_write_en == ~$past(sel_n_vec);
   endproperty
   a_select_sampled: assert property (p_select_sampled)
      else $error("lane enables do not follow sampled selects");

   property p_byte_enable_gate;
      @(posedge clk) disable iff (rst)
      (all_lanes_write_n && byte_write_enable_n) |=> lane_write_en == 4'h0;
   endproperty
   a_byte_enable_gate: assert property (p_byte_enable_gate)
      else $error("lane written without byte write enable");

   property p_global_write;
      @(posedge clk) disable iff (rst)
      !all_lanes_write_n |=> lane_write_en == 4'hf && cycle_kind == sac_pkg::SAC_CYC_WRITE;
   endproperty
   a_global_write: assert property (p_global_write)
      else $error("global write did not enable all lanes");

   property p_lane_map;
      @(posedge clk) disable iff (rst)
      (!all_lanes_write_n || (!byte_write_enable_n && !lane2_write_sel_n)) |=>
         write_word[26:18] == $past({lane2_parity, lane2_data});
   endproperty
   a_lane_map: assert property (p_lane_map)
      else $error("lane two data or parity misrouted");

   property p_lane_hold;
      @(posedge clk) disable iff (rst)
      (all_lanes_write_n && (byte_write_enable_n || lane1_write_sel_n)) |=>
         $stable(write_word[17:9]) && !lane_write_en[1];
   endproperty
   a_lane_hold: assert property (p_lane_hold)
      else $error("unselected lane word changed");

   property p_proc_priority;
      @(posedge clk) disable iff (rst)
      (!proc_addr_strobe_n && !ctrl_addr_strobe_n && chips_selected) |=> strobe_was_proc;
   endproperty
   a_proc_priority: assert property (p_proc_priority)
      else $error("controller strobe won over processor strobe");

   property p_read_cycle;
      @(posedge clk) disable iff (rst)
      (all_lanes_write_n && (byte_write_enable_n || &sel_n_vec)) |=>
         cycle_kind == sac_pkg::SAC_CYC_READ && $stable(write_word);
   endproperty
   a_read_cycle: assert property (p_read_cycle)
      else $error("non-write cycle not treated as read");

   c_proc_capture: cover property (@(posedge clk) disable iff (rst)
      capture && !proc_addr_strobe_n ##1 addr_captured);
   c_ctrl_capture: cover property (@(posedge clk) disable iff (rst)
      capture && proc_addr_strobe_n ##1 !strobe_was_proc);
   c_partial_write: cover property (@(posedge clk) disable iff (rst)
      all_lanes_write_n ##1 lane_write_en == 4'h5);
   c_global_write: cover property (@(posedge clk) disable iff (rst)
      !all_lanes_write_n && !byte_write_enable_n ##1 lane_write_en == 4'hf);

endmodule : sac_capture

`default_nettype wire

// file: sac_pkg.sv
`default_nettype none

package sac_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int ADDR_W = 19;
   localparam int UPPER_W = 17;
   localparam int BURST_W = 2;
   localparam int LANES = 4;
   localparam int LANE_DATA_W = 8;
   localparam int LANE_W = 9;
   localparam int WORD_W = 36;

   // ----------------------------------------
   // field positions inside a lane word
   // ----------------------------------------
   localparam int LANE_PARITY_POS = 8;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [UPPER_W-1:0] UPPER_RST = 17'h00000;
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
   localparam logic [LANE_W-1:0] LANE_RST = 9'h000;

   // ----------------------------------------
   // kind of the sampled cycle, gray along idle, read, write
   // ----------------------------------------
   typedef enum logic [1:0] {
      SAC_CYC_IDLE = 2'h0,
      SAC_CYC_READ = 2'h1,
      SAC_CYC_WRITE = 2'h3
   } sac_cycle_e;

endpackage : sac_pkg

`default_nettype wire

// file: sac_lane.sv
`timescale 1ns/1ns
`default_nettype none

module sac_lane (
   input wire logic clk,
   input wire logic rst,
   input wire logic write_sel_n,
   input wire logic byte_write_enable_n,
   input wire logic all_lanes_write_n,
   input wire logic [sac_pkg::LANE_DATA_W-1:0] lane_data,
   input wire logic lane_parity,
   output logic next_write_en,
   output logic write_en,
   output logic [sac_pkg::LANE_W-1:0] lane_word
);

   // ----------------------------------------
   // lane write decision
   // ----------------------------------------
   // global write wins, else select qualified by byte write enable
   always_comb begin
      next_write_en = !all_lanes_write_n || (!byte_write_enable_n && !write_sel_n);
   end

   // ----------------------------------------
   // lane registers
   // ----------------------------------------
   // write strobe taken on the rising edge
   always_ff @(posedge clk) begin
      if (rst) begin
         write_en <= 1'h0;
      end else begin
         write_en <= next_write_en;
      end
   end

   // data and parity travel together under one select
   always_ff @(posedge clk) begin
      if (rst) begin
         lane_word <= sac_pkg::LANE_RST;
      end else if (next_write_en) begin
         lane_word <= {lane_parity, lane_data};
      end
   end

endmodule : sac_lane

`default_nettype wire

// file: sac_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none

// memory controller on the far side of the capture stage
module sac_ctrl_model (
   input wire logic clk,
   output logic [sac_pkg::ADDR_W-1:0] addr,
   output logic [1:0] strobe_n,
   output logic [2:0] chips,
   output logic [1:0] wr_n,
   output logic [3:0] sel_n,
   output logic [sac_pkg::WORD_W-1:0] word
);
   // idle bus until the first cycle, driven from the bench's process only
   task automatic idle();
      addr = '0;
      strobe_n = 2'h3;
      chips = 3'h5;
      wr_n = 2'h3;
      sel_n = 4'hf;
      word = '0;
   endtask : idle

   // one cycle: launched at the falling edge, held through the rising edge
   task automatic drive(input logic [sac_pkg::ADDR_W-1:0] a, input logic [1:0] s,
         input logic [2:0] c, input logic [1:0] w, input logic [3:0] b,
         input logic [sac_pkg::WORD_W-1:0] d);
      @(negedge clk);
      addr = a;
      strobe_n = s;
      chips = c;
      sel_n = b;
      wr_n = w;
      // data released when both write pins are high: show no stale value
      word = (w == 2'h3) ? ~word : d;
   endtask : drive
endmodule : sac_ctrl_model

`default_nettype wire

// file: sac_capture_tb.sv
`timescale 1ns/1ns
`default_nettype none

module sac_capture_tb;
   localparam int RUN_CYCLES = 400;
   logic clk;
   logic rst;
   logic [18:0] addr;
   logic [1:0] strobe_n;
   logic [2:0] chips;
   logic [1:0] wr_n;
   logic [3:0] sel_n;
   logic [35:0] word;
   logic [16:0] addr_held;
   logic [1:0] burst_count;
   logic addr_captured;
   logic strobe_was_proc;
   logic [3:0] lane_write_en;
   logic [35:0] write_word;
   sac_pkg::sac_cycle_e cycle_kind;
   logic [16:0] e_addr;
   logic [1:0] e_burst;
   logic e_proc;
   logic [35:0] e_word;
   int n_mismatch;
   int n_checks;

   sac_ctrl_model i_sac_ctrl_model (.clk(clk), .addr(addr), .strobe_n(strobe_n),
      .chips(chips), .wr_n(wr_n), .sel_n(sel_n), .word(word));

   // lane i = word[9i+8:9i] as {parity, data}
   sac_capture i_sac_capture (.clk(clk), .rst(rst), .addr_bit_zero(addr[0]),
      .addr_bit_one(addr[1]), .addr_upper(addr[18:2]), .proc_addr_strobe_n(strobe_n[1]),
      .ctrl_addr_strobe_n(strobe_n[0]), .chip_sel_first_n(chips[2]),
      .chip_sel_second(chips[1]), .chip_sel_third_n(chips[0]), .all_lanes_write_n(wr_n[1]),
      .byte_write_enable_n(wr_n[0]), .lane0_write_sel_n(sel_n[0]),
      .lane1_write_sel_n(sel_n[1]), .lane2_write_sel_n(sel_n[2]),
      .lane3_write_sel_n(sel_n[3]), .lane0_data(word[7:0]), .lane1_data(word[16:9]),
      .lane2_data(word[25:18]), .lane3_data(word[34:27]), .lane0_parity(word[8]),
      .lane1_parity(word[17]), .lane2_parity(word[26]), .lane3_parity(word[35]),
      .addr_held(addr_held), .burst_count(burst_count), .addr_captured(addr_captured),
      .strobe_was_proc(strobe_was_proc), .lane_write_en(lane_write_en),
      .write_word(write_word), .cycle_kind(cycle_kind));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // lanes written: global write wins, else select qualified by byte enable
   function automatic logic [3:0] lane_en(input logic [1:0] w, input logic [3:0] b);
      return w[1] ? (w[0] ? 4'h0 : ~b) : 4'hf;
   endfunction : lane_en

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // one bus cycle and its comparison after the sampling edge
   task automatic step(input logic [1:0] s, input logic [2:0] c, input logic [1:0] w,
         input logic [3:0] b);
      logic [18:0] a;
      logic [35:0] d;
      logic cap;
      logic [3:0] en;
      a = 19'($urandom);
      d = {4'($urandom), $urandom};
      cap = (c == 3'h2) && (s != 2'h3);
      en = lane_en(w, b);
      i_sac_ctrl_model.drive(a, s, c, w, b, d);
      @(posedge clk);
      #1;
      if (cap) begin
         e_addr = a[18:2];
         e_burst = a[1:0];
         e_proc = !s[1];
      end
      for (int i = 0; i < 4; i++) begin
         if (en[i]) e_word[9*i +: 9] = d[9*i +: 9];
      end
      check(addr_captured, cap);
      check(addr_held, e_addr);
      check(burst_count, e_burst);
      check(strobe_was_proc, e_proc);
      check(lane_write_en, en);
      check(write_word, e_word);
      check(cycle_kind, en != 4'h0 ? sac_pkg::SAC_CYC_WRITE : sac_pkg::SAC_CYC_READ);
   endtask : step

   // reset held two edges, all outputs cleared
   task automatic do_reset();
      @(negedge clk);
      rst = 1'h1;
      repeat (2) @(posedge clk);
      #1;
      check({addr_held, burst_count, addr_captured, strobe_was_proc}, '0);
      check({lane_write_en, write_word}, '0);
      check(cycle_kind, sac_pkg::SAC_CYC_IDLE);
      {e_addr, e_burst, e_proc, e_word} = '0;
      @(negedge clk);
      rst = 1'h0;
   endtask : do_reset

   // ----------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end

   initial begin
      #(RUN_CYCLES * 40 * 4);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      logic [2:0] rc;
      rst = 1'h1;
      i_sac_ctrl_model.idle();
      n_mismatch = 0;
      n_checks = 0;
      void'($urandom(9205));
      do_reset();
      step(2'h1, 3'h2, 2'h1, 4'hf);
      step(2'h0, 3'h2, 2'h2, 4'h5);
      step(2'h0, 3'h2, 2'h3, 4'h0);
      step(2'h2, 3'h2, 2'h0, 4'hf);
      step(2'h3, 3'h2, 2'h2, 4'ha);
      for (int i = 0; i < 4; i++) begin
         step(2'h2, 3'h2, 2'h2, ~(4'h1 << i));
      end
      for (int k = 0; k < 3; k++) begin
         step(2'h0, 3'h2 ^ (3'h1 << k), 2'h3, 4'hf);
      end
      step(2'h3, 3'h2, 2'h3, 4'hf);
      do_reset();
      for (int n = 0; n < 300; n++) begin
         rc = ($urandom % 2) ? 3'h2 : 3'($urandom);
         step(2'($urandom), rc, 2'($urandom), 4'($urandom));
      end
      tally_and_finish();
   end
endmodule : sac_capture_tb

`default_nettype wire
